// File: hw/dprs_pkg.sv
// Purpose: Shared constants and types for the downstream port reset sequencer.
// Assumes: 100 MHz core clock, AHB-Lite register access, 32-bit words.
// Notes: All offsets are byte addresses of aligned words.
package dprs_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] DPRS_BRIDGE_CONTROL_OFS = 8'h00;
  localparam logic [7:0] DPRS_SLOT_CONTROL_OFS = 8'h04;
  localparam logic [7:0] DPRS_HOTPLUG_CFG_OFS = 8'h08;
  localparam logic [7:0] DPRS_STATUS_OFS = 8'h0C;
  localparam logic [7:0] DPRS_GPIO_FUNC_OFS = 8'h10;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DPRS_SBR_BIT = 6;
  localparam int DPRS_PCC_BIT = 10;
  localparam int DPRS_MODE_LSB = 0;
  localparam int DPRS_P2R_LSB = 8;
  localparam int DPRS_R2P_LSB = 16;
  localparam int DPRS_DLY_W = 8;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic DPRS_SBR_RST = 1'b0;
  localparam logic DPRS_PCC_RST = 1'b1;
  localparam logic [1:0] DPRS_MODE_RST = 2'h0;
  localparam logic [7:0] DPRS_P2R_RST = 8'h01;
  localparam logic [7:0] DPRS_R2P_RST = 8'h01;
  localparam logic DPRS_GPIO_RST = 1'b0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int DPRS_CLK_MHZ = 100;
  localparam int DPRS_RST_MIN_US = 200;
  localparam int DPRS_RST_MIN_CYC = DPRS_RST_MIN_US * DPRS_CLK_MHZ;
  localparam int DPRS_TICK_US = 10;
  localparam int DPRS_TICK_CYC = DPRS_TICK_US * DPRS_CLK_MHZ;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    DPRS_MODE_PWREN = 2'h0,
    DPRS_MODE_PWRGD = 2'h1,
    DPRS_MODE_HOTRST = 2'h2
  } dprs_mode_t;

  typedef enum logic [5:0] {
    DPRS_ST_OFF = 6'h01,
    DPRS_ST_PWR_WAIT = 6'h02,
    DPRS_ST_PGOOD_WAIT = 6'h04,
    DPRS_ST_ON = 6'h08,
    DPRS_ST_RST_WAIT = 6'h10,
    DPRS_ST_FAULT = 6'h20
  } dprs_state_t;

  typedef struct packed {
    logic [DPRS_DLY_W-1:0] reset_to_power_delay_field;
    logic [DPRS_DLY_W-1:0] power_to_reset_delay_field;
    dprs_mode_t reset_output_mode_field;
  } dprs_cfg_t;

  typedef struct packed {
    logic tx_hot_reset_ts1;
    logic flush_ingress;
    logic port_hold;
    logic sec_ur;
  } dprs_sbr_ctl_t;

endpackage : dprs_pkg

// File: hw/dprs_down_counter.sv
// Purpose: Loadable down-counter that counts on an enable pulse.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Done is high while the count is zero and no load is applied.
`timescale 1ns/1ns
`default_nettype none
module dprs_down_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  // Status
  output logic done
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  logic [W-1:0] cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign done = (cnt_reg == '0) && !load;

endmodule : dprs_down_counter
`default_nettype wire

// File: hw/dprs_sync2.sv
// Purpose: Two-flop synchroniser for a level from a pin.
// Assumes: Input is asynchronous to hclk.
// Notes: Only the second flop is visible.
`timescale 1ns/1ns
`default_nettype none
module dprs_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Data
  input wire logic d,
  output logic q
);

  // ==========================================================================
  // Flops
  // ==========================================================================
  logic meta_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : dprs_sync2
`default_nettype wire

// File: hw/dprs_top.sv
// Purpose: Reset sequencing for one downstream port of a packet switch.
// Assumes: hclk at 100 MHz; AHB-Lite single word transfers; power good
//          comes from a pin and is synchronised here.
// Notes: Delay fields count in ticks of a divided enable pulse.
`timescale 1ns/1ns
`default_nettype none
module dprs_top
  import dprs_pkg::*;
#(
  parameter int RST_MIN_CYC = DPRS_RST_MIN_CYC,
  parameter int TICK_CYC = DPRS_TICK_CYC
) (
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Port link and switch core
  input wire logic link_up,
  input wire logic port_hot_reset,
  output logic tx_hot_reset_ts1,
  output logic flush_ingress,
  output logic port_hold,
  output logic sec_ur,
  // Slot pins
  input wire logic port_power_good_in,
  output logic port_power_enable_out,
  output logic port_reset_out_n_o,
  output logic port_reset_out_n_oe
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic secondary_bus_reset_bit;
  logic slot_power_controller_bit;
  dprs_cfg_t cfg_reg;
  logic gpio_alt_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic pgood;
  logic link_up_reg;
  logic hot_reset_reg;
  dprs_state_t state_reg;
  logic rst_asserted_reg;
  logic pwr_en_reg;
  logic [31:0] min_cnt_reg;
  logic [15:0] tick_cnt_reg;
  logic tick_reg;
  logic dly_load;
  logic [DPRS_DLY_W-1:0] dly_val;
  logic dly_done;
  logic min_met;
  logic want_reset;

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  wire addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
    end
  end

  // Register writes never stall, so access survives any port reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      secondary_bus_reset_bit <= DPRS_SBR_RST;
      slot_power_controller_bit <= DPRS_PCC_RST;
      cfg_reg <= {DPRS_R2P_RST, DPRS_P2R_RST, DPRS_MODE_RST};
      gpio_alt_reg <= DPRS_GPIO_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == DPRS_BRIDGE_CONTROL_OFS) begin
        secondary_bus_reset_bit <= hwdata[DPRS_SBR_BIT];
      end else if (wr_addr_reg == DPRS_SLOT_CONTROL_OFS) begin
        slot_power_controller_bit <= hwdata[DPRS_PCC_BIT];
      end else if (wr_addr_reg == DPRS_HOTPLUG_CFG_OFS) begin
        cfg_reg.reset_output_mode_field <= dprs_mode_t'(hwdata[DPRS_MODE_LSB +: 2]);
        cfg_reg.power_to_reset_delay_field <= hwdata[DPRS_P2R_LSB +: DPRS_DLY_W];
        cfg_reg.reset_to_power_delay_field <= hwdata[DPRS_R2P_LSB +: DPRS_DLY_W];
      end else if (wr_addr_reg == DPRS_GPIO_FUNC_OFS) begin
        gpio_alt_reg <= hwdata[0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        if (haddr == DPRS_BRIDGE_CONTROL_OFS) begin
          hrdata <= 32'(secondary_bus_reset_bit) << DPRS_SBR_BIT;
        end else if (haddr == DPRS_SLOT_CONTROL_OFS) begin
          hrdata <= 32'(slot_power_controller_bit) << DPRS_PCC_BIT;
        end else if (haddr == DPRS_HOTPLUG_CFG_OFS) begin
          hrdata <= {8'h00, cfg_reg.reset_to_power_delay_field,
                     cfg_reg.power_to_reset_delay_field, 6'h00,
                     cfg_reg.reset_output_mode_field};
        end else if (haddr == DPRS_STATUS_OFS) begin
          hrdata <= {24'h00_0000, 2'h0, state_reg[5:3], pgood, pwr_en_reg,
                     rst_asserted_reg};
        end else if (haddr == DPRS_GPIO_FUNC_OFS) begin
          hrdata <= {31'h0000_0000, gpio_alt_reg};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================================
  // Input synchronisation and tick divider
  // ==========================================================================
  dprs_sync2 #(.RST_VAL(1'b0)) u_pgood_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(port_power_good_in),
    .q(pgood)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_up_reg <= 1'b0;
      hot_reset_reg <= 1'b0;
    end else begin
      link_up_reg <= link_up;
      hot_reset_reg <= port_hot_reset;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 16'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Secondary bus reset controls
  // ==========================================================================
  // Only this port's controls move; the upstream and sibling ports see none.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_hot_reset_ts1 <= 1'b0;
      flush_ingress <= 1'b0;
      port_hold <= 1'b0;
      sec_ur <= 1'b0;
    end else begin
      tx_hot_reset_ts1 <= secondary_bus_reset_bit && link_up_reg;
      flush_ingress <= secondary_bus_reset_bit;
      port_hold <= secondary_bus_reset_bit;
      // Type 0 config to the port itself is not gated, only the secondary side.
      sec_ur <= secondary_bus_reset_bit;
    end
  end

  // ==========================================================================
  // Slot power and reset sequencing
  // ==========================================================================
  wire hot_mode = cfg_reg.reset_output_mode_field == DPRS_MODE_HOTRST;
  wire pg_mode = cfg_reg.reset_output_mode_field == DPRS_MODE_PWRGD;
  assign min_met = min_cnt_reg == 32'h0000_0000;

  // Hot-reset mode mirrors any port hot reset or secondary bus reset.
  assign want_reset = hot_mode ? (hot_reset_reg || secondary_bus_reset_bit)
                               : (state_reg != DPRS_ST_ON);

  always_comb begin
    dly_load = 1'b0;
    dly_val = cfg_reg.power_to_reset_delay_field;
    case (state_reg)
      DPRS_ST_OFF: begin
        if (!slot_power_controller_bit && !pg_mode) begin
          dly_load = 1'b1;
        end
      end
      DPRS_ST_PGOOD_WAIT: begin
        if (pgood) begin
          dly_load = 1'b1;
        end
      end
      DPRS_ST_ON: begin
        if (slot_power_controller_bit) begin
          dly_load = 1'b1;
          dly_val = cfg_reg.reset_to_power_delay_field;
        end
      end
      default: begin
        dly_load = 1'b0;
      end
    endcase
  end

  dprs_down_counter #(.W(DPRS_DLY_W)) u_dly (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(dly_load),
    .load_val(dly_val),
    .tick(tick_reg),
    .done(dly_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= DPRS_ST_OFF;
      pwr_en_reg <= 1'b0;
    end else begin
      case (state_reg)
        DPRS_ST_OFF: begin
          if (!slot_power_controller_bit) begin
            pwr_en_reg <= 1'b1;
            state_reg <= pg_mode ? DPRS_ST_PGOOD_WAIT : DPRS_ST_PWR_WAIT;
          end
        end
        DPRS_ST_PGOOD_WAIT: begin
          if (slot_power_controller_bit) begin
            pwr_en_reg <= 1'b0;
            state_reg <= DPRS_ST_OFF;
          end else if (pgood) begin
            state_reg <= DPRS_ST_PWR_WAIT;
          end
        end
        DPRS_ST_PWR_WAIT: begin
          if (slot_power_controller_bit) begin
            pwr_en_reg <= 1'b0;
            state_reg <= DPRS_ST_OFF;
          end else if (dly_done && min_met) begin
            state_reg <= DPRS_ST_ON;
          end
        end
        DPRS_ST_ON: begin
          if (slot_power_controller_bit) begin
            state_reg <= DPRS_ST_RST_WAIT;
          end else if (!pgood && !hot_mode) begin
            state_reg <= DPRS_ST_FAULT;
          end
        end
        DPRS_ST_RST_WAIT: begin
          if (dly_done) begin
            pwr_en_reg <= 1'b0;
            state_reg <= DPRS_ST_OFF;
          end
        end
        DPRS_ST_FAULT: begin
          // Stays in reset until software turns power off and on again.
          if (slot_power_controller_bit) begin
            pwr_en_reg <= 1'b0;
            state_reg <= DPRS_ST_OFF;
          end
        end
        default: begin
          state_reg <= DPRS_ST_OFF;
        end
      endcase
    end
  end

  // ==========================================================================
  // Reset pin with minimum pulse width
  // ==========================================================================
  // The fault path adds two synchroniser cycles; faster boards act externally.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_asserted_reg <= 1'b1;
      min_cnt_reg <= 32'(RST_MIN_CYC);
    end else if (!rst_asserted_reg) begin
      if (want_reset || (!pgood && !hot_mode)) begin
        rst_asserted_reg <= 1'b1;
        min_cnt_reg <= 32'(RST_MIN_CYC);
      end
    end else begin
      if (!min_met) begin
        min_cnt_reg <= min_cnt_reg - 32'h0000_0001;
      end
      if (!want_reset && min_met) begin
        rst_asserted_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_power_enable_out <= 1'b0;
      port_reset_out_n_o <= 1'b0;
      port_reset_out_n_oe <= 1'b0;
    end else begin
      port_power_enable_out <= pwr_en_reg;
      port_reset_out_n_o <= !rst_asserted_reg;
      port_reset_out_n_oe <= gpio_alt_reg;
    end
  end

endmodule : dprs_top
`default_nettype wire

// File: verif/dprs_top_monitor.sv
// Purpose: Port-level assertions for the downstream port reset sequencer.
// Assumes: One hclk domain; hresetn asynchronous, active low.
// Notes: Mode is not visible at the ports, so mode timing is judged by the bench.
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Checker
module dprs_top_monitor #(
  parameter int RST_MIN_CYC = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Port control
  input wire logic link_up,
  input wire logic tx_hot_reset_ts1,
  input wire logic flush_ingress,
  input wire logic port_hold,
  input wire logic sec_ur,
  // Slot pins
  input wire logic port_power_good_in,
  input wire logic port_power_enable_out,
  input wire logic port_reset_out_n_o,
  input wire logic port_reset_out_n_oe
);
  int low_cnt_reg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A counter replaces a long repetition, which would slow the tools badly.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_reg <= 0;
    end else if (port_reset_out_n_o) begin
      low_cnt_reg <= 0;
    end else begin
      low_cnt_reg <= low_cnt_reg + 1;
    end
  end
  sequence s_link_down;
    !link_up [*3];
  endsequence
  sequence s_fault;
    port_reset_out_n_o && !port_power_good_in;
  endsequence
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  property p_pin_input;
    !$past(hresetn) |-> !port_reset_out_n_oe;
  endproperty
  property p_min_width;
    $rose(port_reset_out_n_o) |-> low_cnt_reg >= RST_MIN_CYC;
  endproperty
  property p_sbr_group;
    flush_ingress == port_hold && port_hold == sec_ur;
  endproperty
  property p_ts1_hold;
    tx_hot_reset_ts1 |-> port_hold;
  endproperty
  property p_ts1_link;
    s_link_down |-> !tx_hot_reset_ts1;
  endproperty
  property p_enable_first;
    $rose(port_reset_out_n_o) |-> port_power_enable_out;
  endproperty
  property p_reset_first;
    $fell(port_power_enable_out) |-> !port_reset_out_n_o;
  endproperty
  property p_off_in_reset;
    !port_power_enable_out |-> !port_reset_out_n_o;
  endproperty
  property p_fault;
    s_fault |-> ##[1:4] !port_reset_out_n_o;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not zero-wait okay");
  a_pin_input: assert property (p_pin_input)
    else $error("reset pin driven after reset");
  a_min_width: assert property (p_min_width)
    else $error("reset pulse too short");
  a_sbr_group: assert property (p_sbr_group)
    else $error("port reset outputs disagree");
  a_ts1_hold: assert property (p_ts1_hold)
    else $error("ts1 sent outside port reset");
  a_ts1_link: assert property (p_ts1_link)
    else $error("ts1 sent with link down");
  a_enable_first: assert property (p_enable_first)
    else $error("reset released before power enable");
  a_reset_first: assert property (p_reset_first)
    else $error("power dropped before reset");
  a_off_in_reset: assert property (p_off_in_reset)
    else $error("reset released with power off");
  a_fault: assert property (p_fault)
    else $error("power fault not followed by reset");
endmodule : dprs_top_monitor
bind dprs_top dprs_top_monitor #(.RST_MIN_CYC(RST_MIN_CYC)) dprs_top_monitor_inst (
  .hclk, .hresetn, .hreadyout, .hresp, .link_up, .tx_hot_reset_ts1, .flush_ingress,
  .port_hold, .sec_ur, .port_power_good_in, .port_power_enable_out, .port_reset_out_n_o,
  .port_reset_out_n_oe);
`default_nettype wire

// File: verif/dprs_slot_model.sv
// Purpose: Slot power switch and card reset pin seen from the port.
// Assumes: Supply ramps a fixed number of cycles after enable.
// Notes: The bench commands a slow ramp or a fault.
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Slot model
module dprs_slot_model #(
  parameter int FAST_CYC = 5,
  parameter int SLOW_CYC = 60
) (
  // Clock
  input wire logic hclk,
  // Slot supply
  input wire logic power_enable,
  input wire logic slow,
  input wire logic fault,
  output logic power_good,
  // Card reset pin
  input wire logic reset_n_o,
  input wire logic reset_n_oe,
  output logic reset_pin_n
);
  int ramp;
  initial ramp = 0;
  always @(posedge hclk) begin
    if (!power_enable) begin
      ramp <= 0;
    end else if (ramp < SLOW_CYC) begin
      ramp <= ramp + 1;
    end
  end
  // A fault drops power good at once; any quicker reset would sit off chip.
  assign power_good = !fault && power_enable && (ramp >= (slow ? SLOW_CYC : FAST_CYC));
  // A released pin falls to the board pull-down and so reads as reset.
  assign reset_pin_n = reset_n_oe ? reset_n_o : 1'h0;
endmodule : dprs_slot_model
`default_nettype wire

// File: verif/testbench.sv
// Purpose: Self-checking bench for the downstream port reset sequencer.
// Assumes: Short minimum width and tick parameters to keep the run brief.
// Notes: Expected cycle windows allow one tick of phase uncertainty.
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// Bench
module testbench;
  import dprs_pkg::*;
  localparam int RST_MIN = 20;
  localparam int TICK = 4;
  localparam int LIMIT = 20000;
  localparam logic [7:0] OFS [5] = '{DPRS_BRIDGE_CONTROL_OFS, DPRS_SLOT_CONTROL_OFS,
    DPRS_HOTPLUG_CFG_OFS, DPRS_GPIO_FUNC_OFS, 8'h20};
  localparam logic [31:0] RST_VAL [5] = '{32'h0, 32'(DPRS_PCC_RST) << DPRS_PCC_BIT,
    {8'h00, DPRS_R2P_RST, DPRS_P2R_RST, 6'h00, DPRS_MODE_RST}, 32'h0, 32'h0};
  logic hclk, hresetn, hsel, hwrite, link_up, port_hot_reset, slow, fault;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic hreadyout, hresp, tx_ts1, flush, hold, sec_ur, pg, pen, rst_o, rst_oe, pin_n;
  int num_errors, comparisons, cycles;
  dprs_top #(.RST_MIN_CYC(RST_MIN), .TICK_CYC(TICK)) dprs_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_up(link_up), .port_hot_reset(port_hot_reset),
    .tx_hot_reset_ts1(tx_ts1), .flush_ingress(flush), .port_hold(hold), .sec_ur(sec_ur),
    .port_power_good_in(pg), .port_power_enable_out(pen), .port_reset_out_n_o(rst_o),
    .port_reset_out_n_oe(rst_oe));
  dprs_slot_model dprs_slot_model_inst (.hclk(hclk), .power_enable(pen), .slow(slow),
    .fault(fault), .power_good(pg), .reset_n_o(rst_o), .reset_n_oe(rst_oe),
    .reset_pin_n(pin_n));
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      conclude();
    end
  end
  task conclude;
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  task chk_in(input string what, input int n, input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi) begin
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, n);
      num_errors++;
    end
  endtask : chk_in
  // The address phase is held until hready is seen high; read data comes at the next one.
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  function automatic logic pick(input int sel);
    case (sel)
      0: return rst_o;
      1: return pen;
      default: return pg;
    endcase
  endfunction : pick
  task wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    while (pick(sel) !== lvl && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    // A level that never comes must not pass silently into the next check.
    if (n >= 3000) begin
      $display("MISMATCH wait signal %0d expected %b seen %b", sel, lvl, pick(sel));
      num_errors++;
    end
  endtask : wait_for
  function automatic logic [31:0] cfg_word(input logic [1:0] m);
    return {8'h00, 8'h04, 8'h05, 6'h00, m};
  endfunction : cfg_word
  task t_regs;
    chk("pin enable", 1'h0, rst_oe);
    chk("pin level", 1'h0, pin_n);
    for (int i = 0; i < 5; i++) begin
      xfer(OFS[i], 1'h0, 32'h0);
      chk("reset value", RST_VAL[i], rd);
    end
    xfer(DPRS_GPIO_FUNC_OFS, 1'h1, 32'h1);
    repeat (3) @(posedge hclk);
    chk("pin driven", 1'h1, rst_oe);
    chk("pin in reset", 1'h0, pin_n);
  endtask : t_regs
  task t_power_on(input logic [1:0] mode);
    int n;
    slow <= (mode == DPRS_MODE_PWRGD);
    xfer(DPRS_HOTPLUG_CFG_OFS, 1'h1, cfg_word(mode));
    xfer(DPRS_SLOT_CONTROL_OFS, 1'h1, 32'h0);
    wait_for(1, 1'h1, n);
    chk("reset while enabling", 1'h0, rst_o);
    if (mode == DPRS_MODE_PWRGD) begin
      wait_for(2, 1'h1, n);
      chk("reset before power good", 1'h0, rst_o);
    end
    wait_for(0, 1'h1, n);
    chk_in("power to reset cycles", n, 4 * TICK, 6 * TICK + 6);
    chk("pin released", 1'h1, pin_n);
  endtask : t_power_on
  task t_sbr;
    link_up <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      xfer(DPRS_BRIDGE_CONTROL_OFS, 1'h1, 32'h1 << DPRS_SBR_BIT);
      repeat (3) @(posedge hclk);
      chk("reset outputs", i ? 4'h7 : 4'hF, {tx_ts1, flush, hold, sec_ur});
      xfer(DPRS_BRIDGE_CONTROL_OFS, 1'h0, 32'h0);
      chk("bridge readback", 32'h1 << DPRS_SBR_BIT, rd);
      chk("slot reset kept", 1'h1, rst_o);
      xfer(DPRS_BRIDGE_CONTROL_OFS, 1'h1, 32'h0);
      repeat (3) @(posedge hclk);
      chk("outputs released", 4'h0, {tx_ts1, flush, hold, sec_ur});
      link_up <= 1'h0;
      repeat (3) @(posedge hclk);
    end
  endtask : t_sbr
  task t_power_off;
    int n;
    xfer(DPRS_SLOT_CONTROL_OFS, 1'h1, 32'h1 << DPRS_PCC_BIT);
    wait_for(0, 1'h0, n);
    chk("enable held after reset", 1'h1, pen);
    wait_for(1, 1'h0, n);
    chk_in("reset to power cycles", n, 3 * TICK, 5 * TICK + 4);
  endtask : t_power_off
  task t_fault;
    int n;
    fault <= 1'h1;
    @(posedge hclk);
    wait_for(0, 1'h0, n);
    chk_in("fault to reset cycles", n, 0, 4);
    fault <= 1'h0;
    repeat (30) @(posedge hclk);
    chk("reset held after fault", 1'h0, rst_o);
    xfer(DPRS_STATUS_OFS, 1'h0, 32'h0);
    chk("status in fault", 32'h0000_0027, rd);
    xfer(DPRS_SLOT_CONTROL_OFS, 1'h1, 32'h1 << DPRS_PCC_BIT);
    wait_for(1, 1'h0, n);
  endtask : t_fault
  task t_hot_reset;
    int n;
    xfer(DPRS_HOTPLUG_CFG_OFS, 1'h1, cfg_word(DPRS_MODE_HOTRST));
    port_hot_reset <= 1'h1;
    repeat (4) @(posedge hclk);
    chk("reset on hot reset", 1'h0, rst_o);
    port_hot_reset <= 1'h0;
    wait_for(0, 1'h1, n);
    chk_in("hot reset release cycles", n, RST_MIN - 6, RST_MIN + 4);
    xfer(DPRS_BRIDGE_CONTROL_OFS, 1'h1, 32'h1 << DPRS_SBR_BIT);
    repeat (3) @(posedge hclk);
    chk("reset on bus reset", 1'h0, rst_o);
    xfer(DPRS_BRIDGE_CONTROL_OFS, 1'h1, 32'h0);
    wait_for(0, 1'h1, n);
    chk_in("bus reset release cycles", n, 0, RST_MIN + 4);
  endtask : t_hot_reset
  initial begin
    hclk = 1'h0;
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    link_up = 1'h1;
    port_hot_reset = 1'h0;
    slow = 1'h0;
    fault = 1'h0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs();
    t_power_on(DPRS_MODE_PWREN);
    t_sbr();
    t_power_off();
    t_power_on(DPRS_MODE_PWRGD);
    t_fault();
    t_power_on(DPRS_MODE_PWREN);
    t_hot_reset();
    conclude();
  end
endmodule : testbench
`default_nettype wire
